// *** design/brc_pkg.sv ***
package brc_pkg;

  // register byte offsets on the wishbone port
  localparam logic [7:0] OFS_IRQ_EN0 = 8'h00;
  localparam logic [7:0] OFS_IRQ_EN1 = 8'h04;
  localparam logic [7:0] OFS_IRQ_EN2 = 8'h08;
  localparam logic [7:0] OFS_IRQ_EN3 = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_SOFT_IRQ_SET = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h18;
  localparam logic [7:0] OFS_BUS_IRQ_LEVEL = 8'h1C;
  localparam logic [7:0] OFS_BUS_IRQ_VECTOR = 8'h20;
  localparam logic [7:0] OFS_GLOBAL_FIRST = 8'h24;
  localparam logic [7:0] OFS_GLOBAL_SECOND = 8'h28;
  localparam logic [7:0] OFS_BOARD_IDENT = 8'h2C;
  localparam logic [7:0] OFS_GP_BYTE0 = 8'h30;
  localparam logic [7:0] OFS_GP_BYTE4 = 8'h40;
  localparam logic [7:0] OFS_UTILITY_CTRL = 8'h44;
  localparam logic [7:0] OFS_GLOBAL_RESET_REQ = 8'h48;
  localparam logic [7:0] OFS_CPU_CTRL_STATUS = 8'h4C;
  localparam logic [7:0] OFS_ERROR = 8'h50;
  localparam logic [7:0] OFS_PROC_CONFIG = 8'h54;
  localparam logic [7:0] OFS_RESET_STATUS = 8'h58;

  // field positions
  localparam int BIT_BOARD_FAIL = 4;
  localparam int BIT_RESET_HOLD = 2;
  localparam int BIT_POWERED_UP = 14;
  localparam int BIT_DRIVE_SYSFAIL = 13;
  localparam int BIT_BUS_IRQ1_OUT = 12;
  localparam int BIT_ARB_TIMEOUT_EN = 5;
  localparam int BIT_WDOG_OUT_EN = 2;
  localparam int BIT_ABORT_IRQ = 31;
  localparam int BIT_AC_FAIL_IRQ = 30;
  localparam int BIT_SERIAL_TIMER_IRQ = 28;
  localparam int BIT_SYSFAIL_IRQ = 20;
  localparam int BIT_DI_IRQ = 17;

  // interrupt bits kept in flops here; soft irqs at 27..24 and 3..0
  localparam logic [31:0] SOFT_IRQ_MASK = 32'h0F00_000F;
  localparam logic [31:0] LATCH_IRQ_MASK = 32'hC012_0000 | SOFT_IRQ_MASK;
  // bits cleared by a reduced local reset (serial timer is a level)
  localparam logic [31:0] LOCAL_IRQ_CLEAR = 32'hD012_0000 | SOFT_IRQ_MASK;
  localparam logic [15:0] UTIL_LOCAL_CLEAR = 16'h3024;

  // reset values
  localparam logic [15:0] UTIL_POR_VALUE = 16'h061B;
  localparam logic [7:0] GLOBAL_FIRST_RESET = 8'hFF;
  localparam logic [7:0] GLOBAL_SECOND_NOT_CTRL = 8'h10;
  localparam logic [7:0] GLOBAL_SECOND_CTRL = 8'h50;
  localparam logic [7:0] GP_BYTE0_RESET = 8'hFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int GLB_RESET_MAX_NS = 32000;
  // longest time: round down
  localparam int GLB_RESET_CYCLES = GLB_RESET_MAX_NS / CLK_PERIOD_NS;

endpackage : brc_pkg

// *** design/brc_sync.sv ***
`timescale 1ns/100ps
module brc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // levels
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // two-flop synchroniser; the first stage feeds only the second
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;
endmodule : brc_sync

// *** design/brc_timer.sv ***
`timescale 1ns/100ps
module brc_timer (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // control
  input wire logic i_run,
  output logic o_done
);
  import brc_pkg::*;

  localparam logic [11:0] LAST = 12'(GLB_RESET_CYCLES - 1);

  logic [11:0] cnt_r;
  logic [11:0] cnt_nxt;

  // counts while running, restarts from zero whenever run drops
  always_comb begin
    cnt_nxt = 12'h000;
    if (i_run && cnt_r != LAST) begin
      cnt_nxt = cnt_r + 12'h001;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r <= 12'h000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign o_done = i_run && (cnt_r == LAST);
endmodule : brc_timer

// *** design/brc_board_reset_control.sv ***
// The implementer's own choices: the register addresses and register access over Wishbone.
`timescale 1ns/100ps
// Functional notes
// - local reset comes from watchdog expiry, the panel switch when not controller, or reset-hold.
// - every register cleared by local reset is also initialised by system reset.
// - any write to the global reset request register makes a system reset request pending.
// - a pending global reset request produces a system reset within 32 us.
// - any local reset source active while a request is pending cancels the request.
// - system-bus accesses while the board is in reset end with a bus error.
// - all resets clear the four interrupt enables and the bus irq level and vector.
// - local reset clears only selected irq sources; full resets clear every latched flag, but level sources still show in status.
// - local reset sets only board-fail; system reset loads 0x10, or 0x50 as controller; power-on loads 0x10.
// - local reset clears only utility bits 13, 12, 5 and 2.
// - power-on loads utility 0x061B; system reset keeps bit 14 and loads the rest.
// - full resets load 0xFF/zero into global first, ident, gp, cpu, error and config registers.
// - a build strap makes local reset load exactly the system reset values.
// - the serial chip resets on every reset, the counter chip only on full resets.
module brc_board_reset_control (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  output logic o_wb_err,
  // reset sources and straps
  input wire logic i_watchdog_expire,
  input wire logic i_panel_reset_sw,
  input wire logic i_system_controller_select,
  input wire logic i_full_local_reset,
  input wire logic i_ext_system_reset,
  // interrupt sources
  input wire logic i_abort_evt,
  input wire logic i_acfail_evt,
  input wire logic i_sysfail_evt,
  input wire logic i_di_evt,
  input wire logic [31:0] i_irq_level,
  // system-bus slave handshake
  input wire logic i_sb_req,
  output logic o_sb_ack,
  output logic o_sb_berr,
  // resets and state out
  output logic o_local_reset,
  output logic o_system_reset,
  output logic o_serial_chip_reset,
  output logic o_counter_chip_reset,
  output logic [3:0] o_cpu_irq,
  output logic [15:0] o_utility_ctrl
);
  import brc_pkg::*;

  // byte-lane write merge used by every writable register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] din,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = din[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // source synchronisation

  logic [6:0] raw_src;
  logic [6:0] syn_src;
  logic wdog_s, panel_s, system_controller_select_s, full_s, ext_s, abort_s, acfail_s;

  assign raw_src = {i_watchdog_expire, i_panel_reset_sw, i_system_controller_select,
                    i_full_local_reset, i_ext_system_reset, i_abort_evt, i_acfail_evt};
  assign {wdog_s, panel_s, system_controller_select_s, full_s, ext_s, abort_s, acfail_s} = syn_src;

  brc_sync #(.W(7)) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_async(raw_src),
    .o_sync(syn_src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [31:0] en_r [4];
  logic [31:0] en_nxt [4];
  logic [31:0] latch_r, latch_nxt;
  logic [7:0] blevel_r, blevel_nxt, bvector_r, bvector_nxt;
  logic [7:0] gfirst_r, gfirst_nxt, gsecond_r, gsecond_nxt, ident_r, ident_nxt;
  logic [7:0] gp_r [5];
  logic [7:0] gp_nxt [5];
  logic [15:0] util_r, util_nxt;
  logic [31:0] ccs_r, ccs_nxt, err_r, err_nxt, pcfg_r, pcfg_nxt;
  logic pend_r, pend_nxt, por_r, local_reset_r, local_reset_nxt, system_reset_r, system_reset_nxt;
  logic abort_d_r, acfail_d_r;
  logic ack_r, ack_nxt, berr_r, berr_nxt;
  logic [31:0] rdat_r, rdat_nxt;

  logic glb_fire, local_reset_src, system_reset_src, full_load, part_load, in_reset, wr, rd_hit;
  logic [31:0] status, wdat_irq;
  logic [7:0] gsecond_reset;

  // a request is answered once per strobe, one cycle later
  assign wr = i_wb_cyc && i_wb_stb && i_wb_we && !ack_r && !berr_r;
  assign status = latch_r | (i_irq_level & ~LATCH_IRQ_MASK);
  assign gsecond_reset = system_controller_select_s ? GLOBAL_SECOND_CTRL : GLOBAL_SECOND_NOT_CTRL;

  // local sources, a system reset also implies a local one
  assign local_reset_src = wdog_s || (panel_s && !system_controller_select_s) || gsecond_r[BIT_RESET_HOLD];
  assign system_reset_src = ext_s || glb_fire;
  // the strap turns a local reset into a full register load
  assign full_load = system_reset_r || por_r || (local_reset_r && full_s);
  assign part_load = local_reset_r && !full_load;
  assign in_reset = local_reset_r || system_reset_r || por_r;

  brc_timer u_glb_timer (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_run(pend_r),
    .o_done(glb_fire)
  );

  // next-state for reset control and the register file
  always_comb begin
    en_nxt = en_r;
    latch_nxt = latch_r;
    blevel_nxt = blevel_r;
    bvector_nxt = bvector_r;
    gfirst_nxt = gfirst_r;
    gsecond_nxt = gsecond_r;
    ident_nxt = ident_r;
    gp_nxt = gp_r;
    util_nxt = util_r;
    ccs_nxt = ccs_r;
    err_nxt = err_r;
    pcfg_nxt = pcfg_r;
    wdat_irq = merge(WORD_ZERO, i_wb_dat, i_wb_sel);
    // registered resets give each one at least a full clock
    local_reset_nxt = local_reset_src || system_reset_src;
    system_reset_nxt = system_reset_src;
    pend_nxt = pend_r && !glb_fire;
    if (wr && i_wb_adr == OFS_GLOBAL_RESET_REQ) begin
      pend_nxt = 1'b1;
    end
    if (local_reset_src) begin
      pend_nxt = 1'b0;
    end
    // software writes
    if (wr) begin
      case (i_wb_adr)
        OFS_IRQ_EN0: en_nxt[0] = merge(en_r[0], i_wb_dat, i_wb_sel);
        OFS_IRQ_EN1: en_nxt[1] = merge(en_r[1], i_wb_dat, i_wb_sel);
        OFS_IRQ_EN2: en_nxt[2] = merge(en_r[2], i_wb_dat, i_wb_sel);
        OFS_IRQ_EN3: en_nxt[3] = merge(en_r[3], i_wb_dat, i_wb_sel);
        OFS_SOFT_IRQ_SET: latch_nxt = latch_r | (wdat_irq & SOFT_IRQ_MASK);
        OFS_IRQ_CLEAR: latch_nxt = latch_r & ~(wdat_irq & LATCH_IRQ_MASK);
        OFS_BUS_IRQ_LEVEL: blevel_nxt = 8'(merge({24'h0, blevel_r}, i_wb_dat, i_wb_sel));
        OFS_BUS_IRQ_VECTOR: bvector_nxt = 8'(merge({24'h0, bvector_r}, i_wb_dat, i_wb_sel));
        OFS_GLOBAL_FIRST: gfirst_nxt = 8'(merge({24'h0, gfirst_r}, i_wb_dat, i_wb_sel));
        OFS_GLOBAL_SECOND: gsecond_nxt = 8'(merge({24'h0, gsecond_r}, i_wb_dat, i_wb_sel));
        OFS_BOARD_IDENT: ident_nxt = 8'(merge({24'h0, ident_r}, i_wb_dat, i_wb_sel));
        OFS_UTILITY_CTRL: util_nxt = 16'(merge({16'h0, util_r}, i_wb_dat, i_wb_sel));
        OFS_CPU_CTRL_STATUS: ccs_nxt = merge(ccs_r, i_wb_dat, i_wb_sel);
        OFS_ERROR: err_nxt = merge(err_r, i_wb_dat, i_wb_sel);
        OFS_PROC_CONFIG: pcfg_nxt = merge(pcfg_r, i_wb_dat, i_wb_sel);
        default: begin
          for (int g = 0; g < 5; g++) begin
            if (i_wb_adr == OFS_GP_BYTE0 + 8'(4 * g)) begin
              gp_nxt[g] = 8'(merge({24'h0, gp_r[g]}, i_wb_dat, i_wb_sel));
            end
          end
        end
      endcase
    end
    // abort and ac-fail set their flag on an edge, sysfail and di while high; a set beats a same-cycle clear
    if (abort_s && !abort_d_r) begin
      latch_nxt[BIT_ABORT_IRQ] = 1'b1;
    end
    if (acfail_s && !acfail_d_r) begin
      latch_nxt[BIT_AC_FAIL_IRQ] = 1'b1;
    end
    if (i_sysfail_evt) begin
      latch_nxt[BIT_SYSFAIL_IRQ] = 1'b1;
    end
    if (i_di_evt) begin
      latch_nxt[BIT_DI_IRQ] = 1'b1;
    end
    // full loads override writes and events; a reduced load overrides only the registers it clears
    if (full_load || part_load) begin
      en_nxt = '{default: WORD_ZERO};
      blevel_nxt = BYTE_ZERO;
      bvector_nxt = BYTE_ZERO;
    end
    if (part_load) begin
      latch_nxt = latch_r & ~LOCAL_IRQ_CLEAR;
      // a write still lands, else the hold bit could never be dropped
      gsecond_nxt = gsecond_nxt | (8'h01 << BIT_BOARD_FAIL);
      util_nxt = util_r & ~UTIL_LOCAL_CLEAR;
    end
    if (full_load) begin
      latch_nxt = WORD_ZERO;
      gsecond_nxt = gsecond_reset;
      gfirst_nxt = GLOBAL_FIRST_RESET;
      ident_nxt = BYTE_ZERO;
      gp_nxt = '{default: BYTE_ZERO};
      gp_nxt[0] = GP_BYTE0_RESET;
      ccs_nxt = WORD_ZERO;
      err_nxt = WORD_ZERO;
      pcfg_nxt = WORD_ZERO;
      util_nxt = UTIL_POR_VALUE & ~(16'h0001 << BIT_POWERED_UP);
      if (!por_r) begin
        util_nxt[BIT_POWERED_UP] = util_r[BIT_POWERED_UP];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone answer: ack or err one cycle after the strobe

  always_comb begin
    rd_hit = 1'b1;
    rdat_nxt = WORD_ZERO;
    case (i_wb_adr)
      OFS_IRQ_EN0: rdat_nxt = en_r[0];
      OFS_IRQ_EN1: rdat_nxt = en_r[1];
      OFS_IRQ_EN2: rdat_nxt = en_r[2];
      OFS_IRQ_EN3: rdat_nxt = en_r[3];
      OFS_IRQ_STATUS: rdat_nxt = status;
      OFS_SOFT_IRQ_SET: rdat_nxt = WORD_ZERO;
      OFS_IRQ_CLEAR: rdat_nxt = WORD_ZERO;
      OFS_BUS_IRQ_LEVEL: rdat_nxt = {24'h0, blevel_r};
      OFS_BUS_IRQ_VECTOR: rdat_nxt = {24'h0, bvector_r};
      OFS_GLOBAL_FIRST: rdat_nxt = {24'h0, gfirst_r};
      OFS_GLOBAL_SECOND: rdat_nxt = {24'h0, gsecond_r};
      OFS_BOARD_IDENT: rdat_nxt = {24'h0, ident_r};
      OFS_UTILITY_CTRL: rdat_nxt = {16'h0, util_r};
      OFS_GLOBAL_RESET_REQ: rdat_nxt = WORD_ZERO;
      OFS_CPU_CTRL_STATUS: rdat_nxt = ccs_r;
      OFS_ERROR: rdat_nxt = err_r;
      OFS_PROC_CONFIG: rdat_nxt = pcfg_r;
      OFS_RESET_STATUS: rdat_nxt = {27'h0, system_controller_select_s, por_r, system_reset_r, local_reset_r, pend_r};
      default: begin
        rd_hit = 1'b0;
        for (int g = 0; g < 5; g++) begin
          if (i_wb_adr == OFS_GP_BYTE0 + 8'(4 * g)) begin
            rd_hit = 1'b1;
            rdat_nxt = {24'h0, gp_r[g]};
          end
        end
      end
    endcase
    ack_nxt = i_wb_cyc && i_wb_stb && !ack_r && !berr_r && rd_hit;
    berr_nxt = i_wb_cyc && i_wb_stb && !ack_r && !berr_r && !rd_hit;
    if (!(i_wb_cyc && i_wb_stb && !i_wb_we)) begin
      rdat_nxt = rdat_r; // hold data between reads
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state registers

  // power-on holds the full load one cycle after release, before the strap has passed the synchroniser
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      en_r <= '{default: WORD_ZERO};
      latch_r <= WORD_ZERO;
      blevel_r <= BYTE_ZERO;
      bvector_r <= BYTE_ZERO;
      gfirst_r <= GLOBAL_FIRST_RESET;
      gsecond_r <= GLOBAL_SECOND_NOT_CTRL;
      ident_r <= BYTE_ZERO;
      gp_r <= '{GP_BYTE0_RESET, BYTE_ZERO, BYTE_ZERO, BYTE_ZERO, BYTE_ZERO};
      util_r <= UTIL_POR_VALUE;
      ccs_r <= WORD_ZERO;
      err_r <= WORD_ZERO;
      pcfg_r <= WORD_ZERO;
      pend_r <= 1'b0;
      por_r <= 1'b1;
      local_reset_r <= 1'b0;
      system_reset_r <= 1'b0;
      abort_d_r <= 1'b0;
      acfail_d_r <= 1'b0;
      ack_r <= 1'b0;
      berr_r <= 1'b0;
      rdat_r <= WORD_ZERO;
    end else begin
      en_r <= en_nxt;
      latch_r <= latch_nxt;
      blevel_r <= blevel_nxt;
      bvector_r <= bvector_nxt;
      gfirst_r <= gfirst_nxt;
      gsecond_r <= gsecond_nxt;
      ident_r <= ident_nxt;
      gp_r <= gp_nxt;
      util_r <= util_nxt;
      ccs_r <= ccs_nxt;
      err_r <= err_nxt;
      pcfg_r <= pcfg_nxt;
      pend_r <= pend_nxt;
      por_r <= 1'b0;
      local_reset_r <= local_reset_nxt;
      system_reset_r <= system_reset_nxt;
      abort_d_r <= abort_s;
      acfail_d_r <= acfail_s;
      ack_r <= ack_nxt;
      berr_r <= berr_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign o_wb_ack = ack_r;
  assign o_wb_err = berr_r;
  assign o_wb_dat = rdat_r;
  // system-bus answer is combinational; the data path sits elsewhere
  assign o_sb_berr = i_sb_req && in_reset;
  assign o_sb_ack = i_sb_req && !in_reset;
  assign o_local_reset = local_reset_r;
  assign o_system_reset = system_reset_r;
  assign o_serial_chip_reset = in_reset;
  assign o_counter_chip_reset = full_load;
  assign o_utility_ctrl = util_r;

  // per-processor request, enable gates the status
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      o_cpu_irq[c] = |(status & en_r[c]);
    end
  end
endmodule : brc_board_reset_control

// *** sim/brc_board_reset_control_monitor.sv ***
`timescale 1ns/100ps
module brc_board_reset_control_monitor
  import brc_pkg::*;
(
  // clock, reset and bus
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic o_wb_ack,
  input wire logic o_wb_err,
  // sources, straps and outputs
  input wire logic i_watchdog_expire,
  input wire logic i_full_local_reset,
  input wire logic i_sb_req,
  input wire logic o_sb_ack,
  input wire logic o_sb_berr,
  input wire logic o_local_reset,
  input wire logic o_system_reset,
  input wire logic o_serial_chip_reset,
  input wire logic o_counter_chip_reset,
  input wire logic [3:0] o_cpu_irq,
  input wire logic [15:0] o_utility_ctrl
);
  localparam int LIMIT = GLB_RESET_CYCLES + 2;
  logic pend_r;
  logic pend_nxt;
  logic [11:0] age_r;
  logic [11:0] age_nxt;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////
  // age of a pending request; a local or system reset output ends it
  always_comb begin
    pend_nxt = pend_r;
    age_nxt = pend_r ? age_r + 12'h001 : 12'h000;
    if (o_local_reset || o_system_reset) begin
      pend_nxt = 1'b0;
    end else if (i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack && !o_wb_err &&
                 i_wb_adr == OFS_GLOBAL_RESET_REQ) begin
      pend_nxt = 1'b1;
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pend_r <= 1'b0;
      age_r <= 12'h000;
    end else begin
      pend_r <= pend_nxt;
      age_r <= age_nxt;
    end
  end
  ////////////////////////////////////////////////////////////
  // two sync flops plus the reset register: three edges
  a_local_from_wdog: assert property (i_watchdog_expire [*3] |=> o_local_reset)
    else $error("watchdog did not raise local reset");
  a_sys_in_local: assert property (o_system_reset |-> o_local_reset)
    else $error("system reset without local reset");
  a_glb_deadline: assert property (pend_r |-> age_r <= LIMIT)
    else $error("pending global request outlived its deadline");
  a_berr_in_reset: assert property (i_sb_req && o_local_reset |-> o_sb_berr && !o_sb_ack)
    else $error("bus access during reset not ended by bus error");
  a_irq_en_clear: assert property (o_local_reset [*2] |-> o_cpu_irq == 4'h0)
    else $error("cpu interrupt seen while enables should be clear");
  a_util_local_bits: assert property (
    o_local_reset [*2] |-> (o_utility_ctrl & UTIL_LOCAL_CLEAR) == 16'h0000)
    else $error("utility bits not cleared by local reset");
  a_util_sys_load: assert property (o_system_reset |=>
    (o_utility_ctrl & 16'hBFFF) == (UTIL_POR_VALUE & 16'hBFFF))
    else $error("utility not loaded by system reset");
  a_powered_up_flag_kept: assert property (o_system_reset |=> $stable(o_utility_ctrl[14]))
    else $error("powered-up flag changed by system reset");
  a_serial_every: assert property (o_local_reset || o_system_reset |-> o_serial_chip_reset)
    else $error("serial chip not reset");
  a_counter_sys: assert property (o_system_reset |-> o_counter_chip_reset)
    else $error("counter chip not reset by system reset");
  a_counter_local: assert property ((!i_full_local_reset) [*4] ##0
    (o_local_reset && !o_system_reset) |-> !o_counter_chip_reset)
    else $error("counter chip reset by reduced local reset");
endmodule : brc_board_reset_control_monitor

bind brc_board_reset_control brc_board_reset_control_monitor i_mon (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .o_wb_ack(o_wb_ack), .o_wb_err(o_wb_err),
  .i_watchdog_expire(i_watchdog_expire), .i_full_local_reset(i_full_local_reset),
  .i_sb_req(i_sb_req), .o_sb_ack(o_sb_ack), .o_sb_berr(o_sb_berr),
  .o_local_reset(o_local_reset), .o_system_reset(o_system_reset),
  .o_serial_chip_reset(o_serial_chip_reset), .o_counter_chip_reset(o_counter_chip_reset),
  .o_cpu_irq(o_cpu_irq), .o_utility_ctrl(o_utility_ctrl));

// *** sim/brc_sb_master_model.sv ***
`timescale 1ns/100ps
module brc_sb_master_model (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // bench command and slave answer
  input wire logic i_go,
  input wire logic i_sb_ack,
  input wire logic i_sb_berr,
  output logic o_sb_req,
  output logic [1:0] o_resp
);
  // single-beat access held until answered, never a locked walk
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sb_req <= 1'b0;
      o_resp <= 2'b00;
    end else if (o_sb_req && (i_sb_ack || i_sb_berr)) begin
      o_sb_req <= 1'b0;
      o_resp <= {i_sb_berr, i_sb_ack};
    end else if (i_go && !o_sb_req) begin
      o_sb_req <= 1'b1;
      o_resp <= 2'b00;
    end
  end
endmodule : brc_sb_master_model

// *** sim/brc_board_reset_control_tb.sv ***
`timescale 1ns/100ps
module brc_board_reset_control_tb;
  import brc_pkg::*;
  typedef struct packed {logic err; logic chk; logic [31:0] dat;} brc_exp_t;
  localparam logic [7:0] RA [19] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h1C, 8'h20,
    8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C, 8'h40, 8'h44, 8'h4C, 8'h50, 8'h54};
  localparam logic [15:0] RV [19] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
    16'hFF, 16'h10, 16'h0, 16'hFF, 16'h0, 16'h0, 16'h0, 16'h0, 16'h061B, 16'h0, 16'h0, 16'h0};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc, stb, we, ack, err, wd, panel, system_controller_select, full, abort_irq, go, sb_req, sb_ack, sb_berr;
  logic local_reset, system_reset, ser_rst, ctr_rst;
  logic [7:0] adr;
  logic [3:0] sel, cpu_irq;
  logic [31:0] wdat, rdat, u, g;
  logic [15:0] util;
  logic [1:0] resp;
  logic [31:0] seed = 32'hD6AF3D1D;
  int error_cnt = 0, compares = 0, cyc_cnt = 0, n;
  brc_exp_t expq[$];
  brc_exp_t e;
  ////////////////////////////////////////////////////////////
  always #10 clk = ~clk;
  brc_board_reset_control i_brc_board_reset_control (.i_sys_clk(clk), .i_rst(rst),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .o_wb_err(err),
    .i_watchdog_expire(wd), .i_panel_reset_sw(panel), .i_system_controller_select(system_controller_select),
    .i_full_local_reset(full), .i_ext_system_reset(1'b0), .i_abort_evt(abort_irq),
    .i_acfail_evt(1'b0), .i_sysfail_evt(1'b0), .i_di_evt(1'b0), .i_irq_level(32'h0),
    .i_sb_req(sb_req), .o_sb_ack(sb_ack), .o_sb_berr(sb_berr), .o_local_reset(local_reset),
    .o_system_reset(system_reset), .o_serial_chip_reset(ser_rst), .o_counter_chip_reset(ctr_rst),
    .o_cpu_irq(cpu_irq), .o_utility_ctrl(util));
  brc_sb_master_model i_brc_sb_master_model (.i_sys_clk(clk), .i_rst(rst), .i_go(go),
    .i_sb_ack(sb_ack), .i_sb_berr(sb_berr), .o_sb_req(sb_req), .o_resp(resp));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xorshift
  task automatic check(input string nm, input logic [31:0] x, input logic [31:0] got);
    compares++;
    if (got !== x) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, x, got);
    end
  endtask : check
  task automatic tally_and_finish();
    if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  // one master on the register bus at a time; note the answer, wait for it
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic ee, input logic c, input logic [31:0] x);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    expq.push_back('{ee, c, x});
    // no wait limit here: the hang guard ends a stuck run
    do begin
      @(posedge clk);
    end while (ack !== 1'b1 && err !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 1'b0, 1'b0, 32'h0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    wb(1'b0, a, 32'h0, 1'b0, 1'b1, x);
  endtask : rd
  task automatic wait_local_reset(input logic v);
    int k;
    k = 0;
    while (local_reset !== v && k < 50) begin
      @(posedge clk);
      k++;
    end
    check("local_reset", 32'(v), 32'(local_reset));
  endtask : wait_local_reset
  // one system-bus access by the far-side master
  task automatic sb(input logic [1:0] x);
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
    check("sb_resp", 32'(x), 32'(resp));
  endtask : sb
  ////////////////////////////////////////////////////////////
  // answer watcher: oldest note against each ack or err
  always @(posedge clk) begin
    if (ack === 1'b1 || err === 1'b1) begin
      e = expq.pop_front();
      check("wb_err", 32'(e.err), 32'(err));
      if (e.chk) check("wb_dat", e.dat, rdat);
    end
  end
  // hang guard: the whole run needs some 3700 cycles
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    {cyc, stb, we, wd, panel, system_controller_select, full, abort_irq, go} = 9'h0;
    adr = 8'h00;
    sel = 4'hF;
    wdat = 32'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 19; i++) rd(RA[i], {16'h0, RV[i]});
    wb(1'b0, 8'h5C, 32'h0, 1'b1, 1'b0, 32'h0);
    wb(1'b1, 8'hFC, xorshift(), 1'b1, 1'b0, 32'h0);
    // reduced local reset through the hold bit
    u = xorshift() | 32'h4000;
    g = xorshift() & 32'hFF;
    wr(OFS_UTILITY_CTRL, u & 32'hFFFF);
    wr(OFS_GP_BYTE0 + 8'h04, g);
    wr(OFS_IRQ_EN0, 32'h8000_0001);
    wr(OFS_SOFT_IRQ_SET, SOFT_IRQ_MASK);
    abort_irq <= 1'b1;
    repeat (4) @(posedge clk);
    abort_irq <= 1'b0;
    rd(OFS_IRQ_STATUS, SOFT_IRQ_MASK | 32'h8000_0000);
    check("cpu_irq", 32'h1, 32'(cpu_irq[0]));
    wr(OFS_GLOBAL_SECOND, 32'h14);
    wait_local_reset(1'b1);
    sb(2'b10);
    check("serial_rst", 32'h1, 32'(ser_rst));
    check("counter_rst", 32'h0, 32'(ctr_rst));
    wr(OFS_GLOBAL_SECOND, 32'h10);
    wait_local_reset(1'b0);
    rd(OFS_IRQ_EN0, 32'h0);
    rd(OFS_IRQ_STATUS, 32'h0);
    rd(OFS_UTILITY_CTRL, u & 32'hFFFF & ~32'h3024);
    rd(OFS_GP_BYTE0 + 8'h04, g);
    rd(OFS_GLOBAL_SECOND, 32'h10);
    // panel counts only when not controller
    system_controller_select <= 1'b1;
    panel <= 1'b1;
    repeat (8) @(posedge clk);
    check("panel_system_controller_select", 32'h0, 32'(local_reset));
    system_controller_select <= 1'b0;
    repeat (3) @(posedge clk);
    wait_local_reset(1'b1);
    panel <= 1'b0;
    wait_local_reset(1'b0);
    sb(2'b01);
    // global request runs to a system reset
    wr(OFS_GLOBAL_RESET_REQ, xorshift());
    n = 0;
    while (system_reset !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    check("sys_deadline", 32'h1, 32'(n <= GLB_RESET_CYCLES + 1));
    wait_local_reset(1'b0);
    rd(OFS_UTILITY_CTRL, 32'h461B);
    rd(OFS_GP_BYTE0 + 8'h04, 32'h0);
    rd(OFS_GP_BYTE0, 32'hFF);
    rd(OFS_GLOBAL_FIRST, 32'hFF);
    rd(OFS_GLOBAL_SECOND, 32'h10);
    // watchdog cancels a pending request
    wr(OFS_GLOBAL_RESET_REQ, xorshift());
    repeat (50) @(posedge clk);
    wd <= 1'b1;
    wait_local_reset(1'b1);
    wd <= 1'b0;
    n = 0;
    repeat (1800) begin
      @(posedge clk);
      if (system_reset !== 1'b0) n++;
    end
    check("no_sys_reset", 32'h0, 32'(n));
    // fitted link: local reset gives system values
    full <= 1'b1;
    repeat (4) @(posedge clk);
    wr(OFS_GP_BYTE0 + 8'h04, xorshift() & 32'hFF);
    wd <= 1'b1;
    wait_local_reset(1'b1);
    check("counter_rst", 32'h1, 32'(ctr_rst));
    wd <= 1'b0;
    wait_local_reset(1'b0);
    rd(OFS_GP_BYTE0 + 8'h04, 32'h0);
    rd(OFS_UTILITY_CTRL, 32'h461B);
    full <= 1'b0;
    // let the watcher compare the last answer first
    @(posedge clk);
    tally_and_finish();
  end
endmodule : brc_board_reset_control_tb
